// ==== rtl/pem_params.svh ====
`ifndef PEM_PARAMS_SVH
`define PEM_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PEM_ADDR_W          16
`define PEM_MASK_ADDR       16'hE50B
`define PEM_PHASE_ADDR      16'hE600
`define PEM_PRIMARY_ADDR    16'hE50E

// ----------------------------------------
// reset values
// ----------------------------------------
`define PEM_MASK_RST        32'h0000_0000
`define PEM_PRIMARY_RST     32'h0000_0000
`define PEM_PHASE_RST       16'h0000

// ----------------------------------------
// primary status / mask bit positions
// ----------------------------------------
`define PEM_B_NL_TOTAL      0
`define PEM_B_NL_FUND       1
`define PEM_B_NL_APP        2
`define PEM_B_VTO           3
`define PEM_B_ITO           6
`define PEM_B_VZX           9
`define PEM_B_IZX           12
`define PEM_B_RST_DONE      15
`define PEM_B_SAG           16
`define PEM_B_OC            17
`define PEM_B_OV            18
`define PEM_B_SEQ           19
`define PEM_B_MISM          20
`define PEM_B_PKI           23
`define PEM_B_PKV           24
`define PEM_B_CRC           25

// implemented mask / status bits (22:21 and 31:26 reserved)
`define PEM_MASK_USED       32'h039F_FFFF
`define PEM_IRQ_USED        32'h039F_7FFF

// ----------------------------------------
// phase source bit positions
// ----------------------------------------
`define PEM_P_OC            3
`define PEM_P_OV            9
`define PEM_P_SAG           12
`define PEM_PHASE_USED      16'h7E38

`endif

// ==== rtl/pem_pkg.sv ====
package pem_pkg;

  // ----------------------------------------
  // phase order watcher
  // ----------------------------------------
  typedef enum logic {
    seq_idle,
    seq_armed
  } seq_state_e;

  // ----------------------------------------
  // top level state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] rdata;
    logic        irq;
    logic        done_seen;
    seq_state_e  seq;
    logic        run_d;
    logic [31:0] crc_ref;
  } pem_state_s;

endpackage

// ==== rtl/power_event_interrupt_mask.sv ====
`include "pem_params.svh"

module power_event_interrupt_mask
  import pem_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [`PEM_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  output logic                        irq_o,
  input  wire logic                   noload_total_i,
  input  wire logic                   noload_fund_i,
  input  wire logic                   noload_app_i,
  input  wire logic [2:0]             volt_crossing_timeout_i,
  input  wire logic [2:0]             curr_crossing_timeout_i,
  input  wire logic [2:0]             volt_crossing_i,
  input  wire logic [2:0]             curr_crossing_i,
  input  wire logic [2:0]             volt_rising_i,
  input  wire logic [2:0]             sag_i,
  input  wire logic [2:0]             overcurrent_i,
  input  wire logic [2:0]             overvoltage_i,
  input  wire logic                   current_sample_valid_i,
  input  wire logic signed [23:0]     summed_phase_current_i,
  input  wire logic signed [23:0]     neutral_current_sample_i,
  input  wire logic [23:0]            neutral_mismatch_threshold_i,
  input  wire logic                   current_peak_period_end_i,
  input  wire logic                   voltage_peak_period_end_i,
  input  wire logic                   run_i,
  input  wire logic [31:0]            checksum_i
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pem_state_s         st_r;
  pem_state_s         st_nxt;
  logic [31:0]        primary_q;
  logic [15:0]        phase_q;
  logic [31:0]        prim_set;
  logic [31:0]        prim_clr;
  logic [15:0]        phase_set;
  logic [15:0]        phase_clr;
  logic [31:0]        irq_mask;
  logic               seq_err;
  logic signed [24:0] mism_diff;
  logic [24:0]        mism_mag;
  logic               mism_hit;
  logic               crc_bad;
  logic               wr_prim;

  // ----------------------------------------
  // flag storage
  // ----------------------------------------
  sticky_flags #(
    .W (32)
  ) u_primary (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (prim_set),
    .clr_i   (prim_clr),
    .flags_o (primary_q)
  );

  sticky_flags #(
    .W (16)
  ) u_phase (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (phase_set),
    .clr_i   (phase_clr),
    .flags_o (phase_q)
  );

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  always_comb begin
    mism_diff = 25'(summed_phase_current_i) - 25'(neutral_current_sample_i);
    mism_mag  = mism_diff[24] ? 25'(-mism_diff) : 25'(mism_diff);
    mism_hit  = current_sample_valid_i && (mism_mag > {1'b0, neutral_mismatch_threshold_i});
    crc_bad   = st_r.run_d && (checksum_i != st_r.crc_ref);
    seq_err   = (st_r.seq == seq_armed) && volt_rising_i[2] && !volt_rising_i[1];
    wr_prim   = wr_i && (addr_i == `PEM_PRIMARY_ADDR);
  end

  always_comb begin
    prim_set                                       = '0;
    prim_set[`PEM_B_NL_TOTAL]                      = noload_total_i;
    prim_set[`PEM_B_NL_FUND]                       = noload_fund_i;
    prim_set[`PEM_B_NL_APP]                        = noload_app_i;
    prim_set[`PEM_B_VTO+2:`PEM_B_VTO]              = volt_crossing_timeout_i;
    prim_set[`PEM_B_ITO+2:`PEM_B_ITO]              = curr_crossing_timeout_i;
    prim_set[`PEM_B_VZX+2:`PEM_B_VZX]              = volt_crossing_i;
    prim_set[`PEM_B_IZX+2:`PEM_B_IZX]              = curr_crossing_i;
    prim_set[`PEM_B_RST_DONE]                      = !st_r.done_seen;
    prim_set[`PEM_B_SAG]                           = |sag_i;
    prim_set[`PEM_B_OC]                            = |overcurrent_i;
    prim_set[`PEM_B_OV]                            = |overvoltage_i;
    prim_set[`PEM_B_SEQ]                           = seq_err;
    prim_set[`PEM_B_MISM]                          = mism_hit;
    prim_set[`PEM_B_PKI]                           = current_peak_period_end_i;
    prim_set[`PEM_B_PKV]                           = voltage_peak_period_end_i;
    prim_set[`PEM_B_CRC]                           = crc_bad;
    prim_clr                                       = wr_prim ? wdata_i : 32'h0000_0000;
  end

  // ----------------------------------------
  // phase source capture
  // ----------------------------------------
  always_comb begin
    phase_set                             = '0;
    phase_set[`PEM_P_OC+2:`PEM_P_OC]      = overcurrent_i;
    phase_set[`PEM_P_OV+2:`PEM_P_OV]      = overvoltage_i;
    phase_set[`PEM_P_SAG+2:`PEM_P_SAG]    = sag_i;
    phase_set                             = phase_set & `PEM_PHASE_USED;
    phase_clr                             = '0;
    phase_clr[`PEM_P_OC+2:`PEM_P_OC]      = {3{prim_clr[`PEM_B_OC]}};
    phase_clr[`PEM_P_OV+2:`PEM_P_OV]      = {3{prim_clr[`PEM_B_OV]}};
    phase_clr[`PEM_P_SAG+2:`PEM_P_SAG]    = {3{prim_clr[`PEM_B_SAG]}};
  end

  // ----------------------------------------
  // interrupt gating
  // ----------------------------------------
  always_comb begin
    irq_mask                  = st_r.mask & `PEM_IRQ_USED;
    irq_mask[`PEM_B_RST_DONE] = 1'b1;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.done_seen = 1'b1;
    st_nxt.run_d     = run_i;
    if (run_i && !st_r.run_d) begin
      st_nxt.crc_ref = checksum_i;
    end
    unique case (st_r.seq)
      seq_idle: begin
        if (volt_rising_i[0]) begin
          st_nxt.seq = seq_armed;
        end
      end
      seq_armed: begin
        if (volt_rising_i[1] || volt_rising_i[2]) begin
          st_nxt.seq = seq_idle;
        end
      end
    endcase
    if (wr_i && (addr_i == `PEM_MASK_ADDR)) begin
      st_nxt.mask = wdata_i;
    end
    st_nxt.irq   = |(primary_q & irq_mask);
    st_nxt.rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        `PEM_MASK_ADDR:                st_nxt.rdata = st_r.mask;
        `PEM_PHASE_ADDR:               st_nxt.rdata = {16'h0000, phase_q};
        `PEM_PRIMARY_ADDR:             st_nxt.rdata = primary_q;
        default:                       st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r.mask      <= `PEM_MASK_RST;
      st_r.rdata     <= 32'h0000_0000;
      st_r.irq       <= 1'b0;
      st_r.done_seen <= 1'b0;
      st_r.seq       <= seq_idle;
      st_r.run_d     <= 1'b0;
      st_r.crc_ref   <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign irq_o   = st_r.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_irq_follows_flag: assert property (
    (|(primary_q & irq_mask)) |=> irq_o
  ) else $error("irq missing after masked flag");

  a_irq_stays_quiet: assert property (
    !(|(primary_q & irq_mask)) |=> !irq_o
  ) else $error("irq without masked flag");

  a_noload_total_flag: assert property (
    noload_total_i |=> primary_q[`PEM_B_NL_TOTAL] ##1 ($past(st_r.mask[`PEM_B_NL_TOTAL]) -> irq_o)
  ) else $error("no-load flag or irq missing");

  a_volt_zx_flag: assert property (
    volt_crossing_i[1] |=> primary_q[`PEM_B_VZX + 1]
  ) else $error("voltage crossing flag missing");

  a_sag_phase_src: assert property (
    sag_i[0] |=> (phase_q[`PEM_P_SAG] && primary_q[`PEM_B_SAG])
  ) else $error("sag phase source missing");

  a_oc_phase_src: assert property (
    overcurrent_i[2] |=> (phase_q[`PEM_P_OC + 2] && primary_q[`PEM_B_OC])
  ) else $error("overcurrent phase source missing");

  a_ov_phase_src: assert property (
    overvoltage_i[1] |=> (phase_q[`PEM_P_OV + 1] && primary_q[`PEM_B_OV])
  ) else $error("overvoltage phase source missing");

  a_phase_reserved_zero: assert property (
    rd_i && (addr_i == `PEM_PHASE_ADDR) |=> ((rdata_o & ~32'h0000_7E38) == 32'h0000_0000)
  ) else $error("reserved phase bits not zero");

  a_seq_err_flag: assert property (
    (st_r.seq == seq_armed) && (volt_rising_i == 3'h4) |=> primary_q[`PEM_B_SEQ]
  ) else $error("phase order error not flagged");

  a_rst_done_irq: assert property (
    primary_q[`PEM_B_RST_DONE] |=> irq_o
  ) else $error("reset-completed does not interrupt");

  a_crc_mismatch: assert property (
    st_r.run_d && run_i && $stable(st_r.crc_ref) && (checksum_i != st_r.crc_ref) |=> primary_q[`PEM_B_CRC]
  ) else $error("checksum change not flagged");

  a_mask_readback: assert property (
    wr_i && (addr_i == `PEM_MASK_ADDR) ##1 rd_i && (addr_i == `PEM_MASK_ADDR) && !wr_i
      |=> rdata_o == $past(wdata_i, 2)
  ) else $error("mask readback differs");

  a_noload_fund_flag: assert property (
    noload_fund_i |=> primary_q[`PEM_B_NL_FUND] ##1 ($past(st_r.mask[`PEM_B_NL_FUND]) -> irq_o)
  ) else $error("fundamental no-load flag or irq missing");

  a_noload_app_flag: assert property (
    noload_app_i |=> primary_q[`PEM_B_NL_APP] ##1 ($past(st_r.mask[`PEM_B_NL_APP]) -> irq_o)
  ) else $error("apparent no-load flag or irq missing");

  a_volt_timeout_flag: assert property (
    volt_crossing_timeout_i[2] |=> primary_q[`PEM_B_VTO + 2]
  ) else $error("missing voltage crossing not flagged");

  a_curr_timeout_flag: assert property (
    curr_crossing_timeout_i[0] |=> primary_q[`PEM_B_ITO]
  ) else $error("missing current crossing not flagged");

  a_curr_zx_flag: assert property (
    curr_crossing_i[2] |=> primary_q[`PEM_B_IZX + 2]
  ) else $error("current crossing flag missing");

  a_sag_irq: assert property (
    (|sag_i) |=> primary_q[`PEM_B_SAG] ##1 ($past(st_r.mask[`PEM_B_SAG]) -> irq_o)
  ) else $error("sag flag or irq missing");

  a_oc_irq: assert property (
    (|overcurrent_i) |=> primary_q[`PEM_B_OC] ##1 ($past(st_r.mask[`PEM_B_OC]) -> irq_o)
  ) else $error("overcurrent flag or irq missing");

  a_ov_irq: assert property (
    (|overvoltage_i) |=> primary_q[`PEM_B_OV] ##1 ($past(st_r.mask[`PEM_B_OV]) -> irq_o)
  ) else $error("overvoltage flag or irq missing");

  a_mismatch_flag: assert property (
    current_sample_valid_i && (
      (int'(summed_phase_current_i) - int'(neutral_current_sample_i) > int'(neutral_mismatch_threshold_i)) ||
      (int'(neutral_current_sample_i) - int'(summed_phase_current_i) > int'(neutral_mismatch_threshold_i)))
      |=> primary_q[`PEM_B_MISM]
  ) else $error("neutral mismatch not flagged");

  a_pki_flag: assert property (
    current_peak_period_end_i |=> primary_q[`PEM_B_PKI]
  ) else $error("current peak period end not flagged");

  a_pkv_flag: assert property (
    voltage_peak_period_end_i |=> primary_q[`PEM_B_PKV]
  ) else $error("voltage peak period end not flagged");

  a_crc_capture: assert property (
    run_i && !st_r.run_d |=> st_r.crc_ref == $past(checksum_i)
  ) else $error("checksum not captured at run");

  a_mask_reset_zero: assert property (
    !st_r.done_seen |-> (st_r.mask == `PEM_MASK_RST) && !irq_o
  ) else $error("mask or irq not zero after reset");

  a_rst_done_set: assert property (
    !st_r.done_seen |=> primary_q[`PEM_B_RST_DONE]
  ) else $error("reset-completed flag not set");

  a_reserved_mask_inert: assert property (
    ((primary_q & st_r.mask & `PEM_IRQ_USED) == 32'h0000_0000) && !primary_q[`PEM_B_RST_DONE] |=> !irq_o
  ) else $error("reserved or inert mask bit raised irq");

  a_ov_clear_pair: assert property (
    wr_i && (addr_i == `PEM_PRIMARY_ADDR) && wdata_i[`PEM_B_OV] && (overvoltage_i == 3'h0)
      |=> !primary_q[`PEM_B_OV] && (phase_q[`PEM_P_OV + 2:`PEM_P_OV] == 3'h0)
  ) else $error("overvoltage flag or phase source not cleared");

  c_crc_change: cover property (
    crc_bad ##1 primary_q[`PEM_B_CRC]
  );

  c_seq_error: cover property (
    (st_r.seq == seq_armed) ##1 primary_q[`PEM_B_SEQ]
  );

  c_sag_irq: cover property (
    sag_i[2] && st_r.mask[`PEM_B_SAG] ##2 irq_o
  );

  c_mismatch: cover property (
    mism_hit ##1 primary_q[`PEM_B_MISM]
  );

  c_flag_clear: cover property (
    primary_q[`PEM_B_OV] ##1 wr_prim ##1 !primary_q[`PEM_B_OV]
  );

endmodule

// ==== rtl/sticky_flags.sv ====
module sticky_flags #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);

  typedef struct packed {
    logic [W-1:0] flags;
  } flags_s;

  flags_s st_r;
  flags_s st_nxt;

  // ----------------------------------------
  // set wins over clear
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        st_nxt.flags[g] = set_i[g] | (st_r.flags[g] & ~clr_i[g]);
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_o = st_r.flags;

endmodule

// ==== test/tb.sv ====
`include "pem_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // stimulus and design signals
  // ----------------------------------------
  logic                   clk_i = 1'b0;
  logic                   rst_b_i = 1'b0;
  logic [`PEM_ADDR_W-1:0] addr_i = '0;
  logic [31:0]            wdata_i = '0;
  logic                   wr_i = 1'b0;
  logic                   rd_i = 1'b0;
  logic [31:0]            rdata_o;
  logic                   irq_o;
  logic                   noload_total_i = 1'b0;
  logic                   noload_fund_i = 1'b0;
  logic                   noload_app_i = 1'b0;
  logic [2:0]             volt_crossing_timeout_i = '0;
  logic [2:0]             curr_crossing_timeout_i = '0;
  logic [2:0]             volt_crossing_i = '0;
  logic [2:0]             curr_crossing_i = '0;
  logic [2:0]             volt_rising_i = '0;
  logic [2:0]             sag_i = '0;
  logic [2:0]             overcurrent_i = '0;
  logic [2:0]             overvoltage_i = '0;
  logic                   current_sample_valid_i = 1'b0;
  logic signed [23:0]     summed_phase_current_i = '0;
  logic signed [23:0]     neutral_current_sample_i = '0;
  logic [23:0]            neutral_mismatch_threshold_i = '0;
  logic                   current_peak_period_end_i = 1'b0;
  logic                   voltage_peak_period_end_i = 1'b0;
  logic                   run_i = 1'b0;
  logic [31:0]            checksum_i = '0;

  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'h0000_0004;

  always #20 clk_i = ~clk_i;

  power_event_interrupt_mask DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .noload_total_i(noload_total_i), .noload_fund_i(noload_fund_i),
    .noload_app_i(noload_app_i), .volt_crossing_timeout_i(volt_crossing_timeout_i),
    .curr_crossing_timeout_i(curr_crossing_timeout_i), .volt_crossing_i(volt_crossing_i),
    .curr_crossing_i(curr_crossing_i), .volt_rising_i(volt_rising_i), .sag_i(sag_i),
    .overcurrent_i(overcurrent_i), .overvoltage_i(overvoltage_i),
    .current_sample_valid_i(current_sample_valid_i), .summed_phase_current_i(summed_phase_current_i),
    .neutral_current_sample_i(neutral_current_sample_i),
    .neutral_mismatch_threshold_i(neutral_mismatch_threshold_i),
    .current_peak_period_end_i(current_peak_period_end_i),
    .voltage_peak_period_end_i(voltage_peak_period_end_i), .run_i(run_i), .checksum_i(checksum_i));

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  logic [31:0] m_mask, m_prim, m_rd, m_ref, set_v, clr_v;
  logic [15:0] m_phase, ph_set, ph_clr;
  logic        m_irq, m_done, m_armed, m_run_d;
  int          diff;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      m_mask = '0;
      m_prim = '0;
      m_rd = '0;
      m_ref = '0;
      m_phase = '0;
      m_irq = 1'b0;
      m_done = 1'b0;
      m_armed = 1'b0;
      m_run_d = 1'b0;
    end else begin
      clr_v = (wr_i && addr_i == `PEM_PRIMARY_ADDR) ? wdata_i : 32'h0000_0000;
      diff = int'(summed_phase_current_i) - int'(neutral_current_sample_i);
      if (diff < 0) diff = -diff;
      set_v = '0;
      set_v[0] = noload_total_i;
      set_v[1] = noload_fund_i;
      set_v[2] = noload_app_i;
      set_v[5:3] = volt_crossing_timeout_i;
      set_v[8:6] = curr_crossing_timeout_i;
      set_v[11:9] = volt_crossing_i;
      set_v[14:12] = curr_crossing_i;
      set_v[15] = !m_done;
      set_v[16] = |sag_i;
      set_v[17] = |overcurrent_i;
      set_v[18] = |overvoltage_i;
      set_v[19] = m_armed && volt_rising_i[2] && !volt_rising_i[1];
      set_v[20] = current_sample_valid_i && diff > int'(neutral_mismatch_threshold_i);
      set_v[23] = current_peak_period_end_i;
      set_v[24] = voltage_peak_period_end_i;
      set_v[25] = m_run_d && checksum_i != m_ref;
      ph_set = {1'b0, sag_i, overvoltage_i, 3'b000, overcurrent_i, 3'b000};
      ph_clr = {1'b0, {3{clr_v[16]}}, {3{clr_v[18]}}, 3'b000, {3{clr_v[17]}}, 3'b000};
      m_irq = |(m_prim & m_mask & `PEM_IRQ_USED) | m_prim[15];
      if (!rd_i) m_rd = '0;
      else if (addr_i == `PEM_MASK_ADDR) m_rd = m_mask;
      else if (addr_i == `PEM_PHASE_ADDR) m_rd = {16'h0000, m_phase};
      else if (addr_i == `PEM_PRIMARY_ADDR) m_rd = m_prim;
      else m_rd = '0;
      if (volt_rising_i[0]) m_armed = 1'b1;
      else if (volt_rising_i[1] || volt_rising_i[2]) m_armed = 1'b0;
      if (run_i && !m_run_d) m_ref = checksum_i;
      m_run_d = run_i;
      m_phase = (m_phase & ~ph_clr) | ph_set;
      m_prim = (m_prim & ~clr_v) | set_v;
      m_done = 1'b1;
      if (wr_i && addr_i == `PEM_MASK_ADDR) m_mask = wdata_i;
    end
  end

  // ----------------------------------------
  // comparison and report
  // ----------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: read data %h, model %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: interrupt %b, model %b", $time, got, exp);
    end
  endtask

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(negedge clk_i) begin
    check_word(rdata_o, m_rd);
    check_bit(irq_o, m_irq);
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic step;
    logic [31:0] r, ev, q1, q2;
    r = rnd();
    ev = rnd() & rnd() & rnd();
    q1 = rnd();
    q2 = rnd();
    @(posedge clk_i);
    wr_i <= (r[1:0] == 2'd0);
    rd_i <= (r[1:0] == 2'd1);
    case (r[3:2])
      2'd0: addr_i <= `PEM_MASK_ADDR;
      2'd1: addr_i <= `PEM_PHASE_ADDR;
      2'd2: addr_i <= `PEM_PRIMARY_ADDR;
      default: addr_i <= q1[31:16];
    endcase
    wdata_i <= rnd();
    {noload_total_i, noload_fund_i, noload_app_i} <= ev[2:0];
    volt_crossing_timeout_i <= ev[5:3];
    curr_crossing_timeout_i <= ev[8:6];
    volt_crossing_i <= ev[11:9];
    curr_crossing_i <= ev[14:12];
    {sag_i, overcurrent_i, overvoltage_i} <= ev[23:15];
    {current_peak_period_end_i, voltage_peak_period_end_i} <= ev[25:24];
    case (r[6:4])
      3'd0: volt_rising_i <= 3'b001;
      3'd1: volt_rising_i <= 3'b010;
      3'd2: volt_rising_i <= 3'b100;
      default: volt_rising_i <= 3'b000;
    endcase
    current_sample_valid_i <= r[7];
    summed_phase_current_i <= {{3{q1[20]}}, q1[20:0]};
    neutral_current_sample_i <= {{3{q2[20]}}, q2[20:0]};
    neutral_mismatch_threshold_i <= {4'h0, r[27:8]};
    if (r[12:8] == 5'd0) run_i <= ~run_i;
    if (r[17:13] == 5'd0) checksum_i <= q2;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3000) step();
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3000) step();
    @(posedge clk_i);
    test_done();
  end
endmodule
